// [sp0u_peer.sv]
`timescale 1ns/1ps
// ****************************************
// far-end serial transceiver
// ****************************************
module sp0u_peer (
	// clock
	input  wire logic sys_clk,
	// serial lines
	input  wire logic txd,
	output logic      rxd
);
	logic [10:0] got;
	initial rxd = 1'b1;
	// samples mid-bit: start, data lsb first, optional ninth, stop
	task automatic recv(input int nb, input int per);
		int i;
		while (txd !== 1'b0) @(posedge sys_clk);
		repeat (per / 2) @(posedge sys_clk);
		for (i = 0; i <= nb; i++) begin
			got[i] = txd;
			repeat (per) @(posedge sys_clk);
		end
	endtask
	// line idles high between frames, as a real transmitter leaves it
	task automatic send(input logic [10:0] frm, input int nb, input int per);
		int i;
		for (i = 0; i <= nb; i++) begin
			rxd <= frm[i];
			repeat (per) @(posedge sys_clk);
		end
		rxd <= 1'b1;
	endtask
endmodule

// [sp0u_pkg.sv]
package sp0u_pkg;
	localparam logic [7:0] OFS_CTRL     = 8'h98;
	localparam logic [7:0] OFS_DATA     = 8'h99;
	localparam logic [7:0] OFS_BAUD     = 8'h9A;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h9B;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h9C;
	localparam logic [7:0] RST_CTRL     = 8'h00;
	localparam logic [7:0] RST_DATA     = 8'h00;
	localparam int BIT_MODE_HI  = 7;
	localparam int BIT_MODE_LO  = 6;
	localparam int BIT_VARIANT  = 5;
	localparam int BIT_RX_EN    = 4;
	localparam int BIT_TX_NINTH = 3;
	localparam int BIT_RX_NINTH = 2;
	localparam int BIT_TX_DONE  = 1;
	localparam int BIT_RX_DONE  = 0;
	localparam int BIT_DOUBLER  = 7;
	localparam int PER_M0_SLOW  = 12;
	localparam int PER_M0_FAST  = 4;
	localparam int PER_M2_STD   = 64;
	localparam int PER_M2_DBL   = 32;
	localparam int OVERSAMPLE   = 16;
	typedef enum logic [1:0] {
		SP0U_M0 = 2'b00,
		SP0U_M1 = 2'b01,
		SP0U_M2 = 2'b10,
		SP0U_M3 = 2'b11
	} sp0u_mode_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sp0u_bus_t;
endpackage

// [sp0u_sync.sv]
`timescale 1ns/1ps
module sp0u_sync
	import sp0u_pkg::*;
#(
	parameter logic INIT = 1'b1
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// pin and filtered level
	input  wire logic pin,
	output logic      level
);
	logic s1;
	logic s2;
	logic s3;
	// first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s1    <= INIT;
			s2    <= INIT;
			s3    <= INIT;
			level <= INIT;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end
endmodule

// [sp0u_uart.sv]
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module sp0u_uart
	import sp0u_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// register port
	input  wire sp0u_bus_t  bus,
	output logic [7:0]      rdData,
	// baud tick from timer logic, 16x oversample
	input  wire logic       baudTick,
	// serial pins: txd line and bidirectional rxd line
	output logic            txdOut,
	input  wire logic       rxdIn,
	output logic            rxdOut,
	output logic            rxdOe,
	// interrupt
	output logic            irq
);
	// ****************************************
	// registers and decode
	// ****************************************
	logic [7:0] ctrl;
	logic [7:0] baudReg;
	logic [7:0] rxBuf;
	logic [1:0] irqStat;
	logic [1:0] irqMask;
	logic       rxLevel;
	sp0u_mode_t mode;
	assign mode = sp0u_mode_t'(ctrl[BIT_MODE_HI:BIT_MODE_LO]);
	wire variant   = ctrl[BIT_VARIANT];
	wire rxEn      = ctrl[BIT_RX_EN];
	wire doubler   = baudReg[BIT_DOUBLER];
	wire selCtrl   = bus.addr == OFS_CTRL;
	wire selData   = bus.addr == OFS_DATA;
	wire selBaud   = bus.addr == OFS_BAUD;
	wire selStat   = bus.addr == OFS_IRQ_STAT;
	wire selMask   = bus.addr == OFS_IRQ_MASK;
	wire wrCtrl    = bus.wr && selCtrl;
	wire wrData    = bus.wr && selData;
	wire rdStat    = bus.rd && selStat;

	sp0u_sync #(.INIT(1'b1)) uSync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pin     (rxdIn),
		.level   (rxLevel)
	);

	// ****************************************
	// bit timing
	// ****************************************
	// frame length in bits; mode 0 words carry no start or stop bit
	function automatic logic [3:0] frame_bits(input sp0u_mode_t m);
		if (m == SP0U_M0) begin
			frame_bits = 4'h8;
		end else if (m[1]) begin
			frame_bits = 4'hB;
		end else begin
			frame_bits = 4'hA;
		end
	endfunction

	// mode 0 and 2 tick counters run off sys_clk; modes 1 and 3 use baudTick
	logic [6:0] divCnt;
	wire [6:0] divLimit = (mode == SP0U_M0) ? (variant ? 7'(PER_M0_FAST) : 7'(PER_M0_SLOW))
		: (doubler ? 7'(PER_M2_DBL / OVERSAMPLE) : 7'(PER_M2_STD / OVERSAMPLE));
	wire divTick = divCnt == divLimit - 7'd1;
	// one oversample tick: mode 0 uses a whole bit period per tick
	wire sTick = (mode == SP0U_M1 || mode == SP0U_M3) ? baudTick : divTick;
	always_ff @(posedge sys_clk) begin
		if (!rst_n || divTick) divCnt <= 7'd0;
		else divCnt <= divCnt + 7'd1;
	end

	// ****************************************
	// transmitter
	// ****************************************
	logic [10:0] txShift;
	logic [3:0]  txBits;
	logic [3:0]  txSub;
	logic        txBusy;
	logic        txDonePulse;
	wire         m0 = mode == SP0U_M0;
	wire         nine = mode[1];
	// frame of start, data, optional ninth, stop: 10 or 11 bits
	wire [10:0]  txFrame = nine ? {1'b1, ctrl[BIT_TX_NINTH], bus.wdata, 1'b0}
		: {2'b11, bus.wdata, 1'b0};
	wire [3:0]   txLen = frame_bits(mode);
	wire         txStep = sTick && (m0 || txSub == 4'(OVERSAMPLE - 1));
	// flag is raised as the last data bit (the ninth bit in 11-bit frames) ends, before the stop bit
	wire         txLastData = txStep && txBits == (m0 ? 4'd1 : 4'd2);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			txShift <= 11'h7FF;
			txBits  <= 4'd0;
			txSub   <= 4'd0;
			txBusy  <= 1'b0;
			txdOut  <= 1'b1;
		end else if (wrData) begin
			txShift <= m0 ? {3'b111, bus.wdata} : txFrame;
			txBits  <= txLen;
			txSub   <= 4'd0;
			txBusy  <= 1'b1;
		end else if (txBusy && sTick) begin
			txSub <= txSub + 4'd1;
			if (txStep) begin
				txShift <= {1'b1, txShift[10:1]};
				txBits  <= txBits - 4'd1;
				txBusy  <= txBits != 4'd1;
			end
			if (!m0) txdOut <= txShift[0];
		end else if (!txBusy) begin
			txdOut <= 1'b1;
		end
	end
	assign txDonePulse = txBusy && txLastData;

	// ****************************************
	// receiver
	// ****************************************
	logic [9:0] rxShift;
	logic [3:0] rxBits;
	logic [3:0] rxSub;
	logic       rxBusy;
	logic       rxDonePulse;
	logic       rxNinth;
	logic       rxPrev;
	wire        rxFall = rxPrev && !rxLevel;
	wire        rxLen9 = nine;
	wire        rxSample = sTick && rxSub == 4'(OVERSAMPLE / 2 - 1);
	wire [3:0]  rxTotal = frame_bits(mode);
	// word ends on the ninth-bit sample in 11-bit frames and on the stop
	// sample in 10-bit frames; both are sample nine after the start
	wire        rxEnd = rxBusy && !m0 && rxSample
		&& rxBits == rxTotal - (rxLen9 ? 4'h2 : 4'h1);
	// frame bits after the start: data then ninth or stop
	wire        lastBit = rxLevel;
	// multiprocessor variant drops a frame whose last bit is low
	wire        keep = !variant || lastBit;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rxShift     <= 10'h000;
			rxBits      <= 4'd0;
			rxSub       <= 4'd0;
			rxBusy      <= 1'b0;
			rxBuf       <= RST_DATA;
			rxPrev      <= 1'b1;
			rxDonePulse <= 1'b0;
			rxNinth     <= 1'b0;
			rxdOut      <= 1'b1;
			rxdOe       <= 1'b0;
		end else begin
			rxPrev      <= rxLevel;
			rxDonePulse <= 1'b0;
			if (m0) begin
				// mode 0 reception driven by receive enable; txd clock stays idle
				if (wrCtrl && bus.wdata[BIT_RX_EN] && !rxBusy) begin
					rxBusy <= 1'b1;
					rxBits <= 4'd0;
				end else if (rxBusy && sTick) begin
					rxShift <= {rxLevel, rxShift[9:1]};
					rxBits  <= rxBits + 4'd1;
					if (rxBits == 4'd7) begin
						rxBusy      <= 1'b0;
						rxBuf       <= {rxLevel, rxShift[9:3]};
						rxDonePulse <= 1'b1;
					end
				end
				// transmit drives rxd as data in mode 0
				rxdOe  <= txBusy;
				rxdOut <= txShift[0];
			end else begin
				rxdOe  <= 1'b0;
				rxdOut <= 1'b1;
				if (!rxBusy) begin
					if (rxEn && rxFall) begin
						rxBusy <= 1'b1;
						rxBits <= 4'd0;
						rxSub  <= 4'd0;
					end
				end else if (sTick) begin
					rxSub <= rxSub + 4'd1;
					if (rxSample) begin
						rxShift <= {rxLevel, rxShift[9:1]};
						rxBits  <= rxBits + 4'd1;
						if (rxBits == 4'd0 && rxLevel) rxBusy <= 1'b0;
					end
					if (rxEnd) begin
						rxBusy <= 1'b0;
						if (keep) begin
							rxBuf <= rxShift[9:2];
							rxNinth <= lastBit;
							rxDonePulse <= 1'b1;
						end
					end
				end
			end
		end
	end

	// ****************************************
	// control, flags and interrupt
	// ****************************************
	// hardware set wins over a software clear in the same cycle
	logic [7:0] next_ctrl;
	always_comb begin
		next_ctrl = ctrl;
		if (wrCtrl) next_ctrl = bus.wdata;
		if (!m0) next_ctrl[BIT_RX_NINTH] = rxDonePulse ? rxNinth : next_ctrl[BIT_RX_NINTH];
		if (txDonePulse) next_ctrl[BIT_TX_DONE] = 1'b1;
		if (rxDonePulse) next_ctrl[BIT_RX_DONE] = 1'b1;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl    <= RST_CTRL;
			baudReg <= 8'h00;
			irqStat <= 2'b00;
			irqMask <= 2'b00;
			rdData  <= 8'h00;
			irq     <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			if (bus.wr && selBaud) baudReg <= bus.wdata;
			if (bus.wr && selMask) irqMask <= bus.wdata[1:0];
			irqStat <= (rdStat ? 2'b00 : irqStat) | {txDonePulse, rxDonePulse};
			irq <= |(((rdStat ? 2'b00 : irqStat) | {txDonePulse, rxDonePulse}) & irqMask);
			if (bus.rd) begin
				if (selCtrl) rdData <= ctrl;
				else if (selData) rdData <= rxBuf;
				else if (selBaud) rdData <= baudReg;
				else if (selStat) rdData <= {6'h00, irqStat};
				else if (selMask) rdData <= {6'h00, irqMask};
				else rdData <= 8'h00;
			end else begin
				rdData <= 8'h00;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_tx_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		txDonePulse |=> ctrl[BIT_TX_DONE]) else $error("transmit flag not set");
	a_rx_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rxDonePulse |=> ctrl[BIT_RX_DONE]) else $error("receive flag not set");
	a_flag_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ctrl[BIT_TX_DONE] && !wrCtrl |=> ctrl[BIT_TX_DONE]) else $error("flag self cleared");
	a_rx_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ctrl[BIT_RX_DONE] && !wrCtrl |=> ctrl[BIT_RX_DONE]) else $error("rx flag self cleared");
	a_tx_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wrData |=> txBusy) else $error("write did not start transmit");
	a_rd_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
		bus.rd && selData |=> rdData == $past(rxBuf)) else $error("data read wrong");
	a_rx_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!m0 && !rxEn && !rxBusy |=> !rxBusy) else $error("receiver ran disabled");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(irqStat & irqMask) != 2'b00 && !rdStat |=> irq) else $error("irq missing");

	// steps of the longer checks
	sequence s_m0_last_bit;
		m0 && rxBusy && sTick && rxBits == 4'h7;
	endsequence
	sequence s_rx_flag_rise;
		rxDonePulse ##1 ctrl[BIT_RX_DONE];
	endsequence
	sequence s_tx_last_data;
		txBusy && !m0 && txLastData && !wrData;
	endsequence
	sequence s_tx_stop_bit;
		txBusy && ctrl[BIT_TX_DONE];
	endsequence
	sequence s_frame_kept;
		rxEnd && keep;
	endsequence
	a_m0_rx_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_m0_last_bit |=> s_rx_flag_rise)
		else $error("mode 0 receive not flagged");
	a_tx_before_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_tx_last_data |=> s_tx_stop_bit)
		else $error("transmit flag not ahead of stop bit");
	a_ninth_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_frame_kept ##1 !m0 |=> ctrl[BIT_RX_NINTH] == $past(lastBit, 2))
		else $error("ninth bit not stored");
	a_mp_discard: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rxEnd && variant && !lastBit |=> !rxDonePulse)
		else $error("frame kept without its address bit");
	a_m0_ninth_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		m0 && !wrCtrl |=> ctrl[BIT_RX_NINTH] == $past(ctrl[BIT_RX_NINTH]))
		else $error("mode 0 touched ninth bit");
	a_m0_rx_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		m0 && wrCtrl && bus.wdata[BIT_RX_EN] && !rxBusy |=> rxBusy)
		else $error("mode 0 receive not started");
	a_oe_mode0: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!m0 |=> !rxdOe)
		else $error("data pin driven outside mode 0");
	a_tx_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wrData && !m0 |=> !txShift[0] && txShift[txBits - 4'h1])
		else $error("frame lacks start or stop bit");
	a_stat_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rdStat && !txDonePulse && !rxDonePulse |=> irqStat == 2'b00)
		else $error("status not cleared by read");
	a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(irqStat & irqMask) == 2'b00 && !txDonePulse && !rxDonePulse |=> !irq)
		else $error("irq without unmasked status");
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import sp0u_pkg::*;
	logic       sys_clk;
	logic       rst_n;
	logic       baudTick = 1'b0;
	logic       peerRxd;
	logic       txdOut;
	logic       rxdOut;
	logic       rxdOe;
	logic       irq;
	wire logic  rxdIn;
	sp0u_bus_t  bus;
	logic [7:0] rdData;
	logic [7:0] v;
	int         err_total = 0;
	int         n_tests = 0;
	int         cyc = 0;
	assign rxdIn = rxdOe ? rxdOut : peerRxd;
	sp0u_uart DUT (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rdData(rdData),
		.baudTick(baudTick), .txdOut(txdOut), .rxdIn(rxdIn), .rxdOut(rxdOut),
		.rxdOe(rxdOe), .irq(irq));
	sp0u_peer peer (.sys_clk(sys_clk), .txd(txdOut), .rxd(peerRxd));
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;
	// tick every 4 clocks: a 16x-sampled bit then spans 64 clocks
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		baudTick <= (cyc % 4 == 3);
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// ****************************************
	// bus tasks and checking
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 v = rdData;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_flag(input int b);
		int k;
		for (k = 0; k < 600; k++) begin
			rd(OFS_CTRL);
			if (v[b] === 1'b1) break;
		end
	endtask
	task automatic tally_and_finish();
		$display("TB: %0d compared, %0d bad", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		rst_n = 1'b0;
		bus = '0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(OFS_CTRL); chk(v, RST_CTRL);
		rd(OFS_DATA); chk(v, RST_DATA);
		rd(8'h9D); chk(v, 8'h00);
		$display("TB: reset test done");
		wr(OFS_IRQ_MASK, 8'h03);
		wr(OFS_CTRL, 8'h88);
		fork
			peer.recv(10, PER_M2_STD);
			wr(OFS_DATA, 8'hA5);
		join
		chk(peer.got[8:1], 8'hA5);
		chk({5'h00, peer.got[0], peer.got[9], peer.got[10]}, 8'h03);
		wait_flag(1); chk(v, 8'h8A);
		rd(OFS_CTRL); chk(v, 8'h8A);
		chk({7'h00, irq}, 8'h01);
		rd(OFS_IRQ_STAT); chk(v, 8'h02);
		rd(OFS_CTRL); chk({7'h00, irq}, 8'h00);
		wr(OFS_CTRL, 8'h80);
		rd(OFS_CTRL); chk(v, 8'h80);
		$display("TB: mode 2 transmit done");
		wr(OFS_IRQ_MASK, 8'h00);
		wr(OFS_BAUD, 8'h80);
		wr(OFS_CTRL, 8'h90);
		peer.send({1'b1, 1'b1, 8'h3C, 1'b0}, 10, PER_M2_DBL);
		wait_flag(0); chk(v, 8'h95);
		chk({7'h00, irq}, 8'h00);
		rd(OFS_DATA); chk(v, 8'h3C);
		rd(OFS_IRQ_STAT); chk(v, 8'h01);
		wr(OFS_CTRL, 8'hB0);
		peer.send({1'b1, 1'b0, 8'h55, 1'b0}, 10, PER_M2_DBL);
		repeat (40) @(posedge sys_clk);
		rd(OFS_CTRL); chk(v, 8'hB0);
		peer.send({1'b1, 1'b1, 8'h66, 1'b0}, 10, PER_M2_DBL);
		wait_flag(0); chk(v, 8'hB5);
		rd(OFS_DATA); chk(v, 8'h66);
		wr(OFS_CTRL, 8'h80);
		peer.send({1'b1, 1'b1, 8'h77, 1'b0}, 10, PER_M2_DBL);
		repeat (40) @(posedge sys_clk);
		rd(OFS_CTRL); chk(v, 8'h80);
		rd(OFS_DATA); chk(v, 8'h66);
		$display("TB: mode 2 receive done");
		wr(OFS_CTRL, 8'hF0);
		peer.send({1'b1, 1'b1, 8'h69, 1'b0}, 10, 64);
		wait_flag(0); chk(v, 8'hF5);
		rd(OFS_DATA); chk(v, 8'h69);
		$display("TB: mode 3 receive done");
		wr(OFS_BAUD, 8'h00);
		wr(OFS_CTRL, 8'h40);
		fork
			peer.recv(9, 64);
			wr(OFS_DATA, 8'h5A);
		join
		chk(peer.got[8:1], 8'h5A);
		chk({6'h00, peer.got[0], peer.got[9]}, 8'h01);
		wait_flag(1); chk(v, 8'h42);
		wr(OFS_CTRL, 8'h50);
		peer.send({2'b11, 8'hC3, 1'b0}, 9, 64);
		wait_flag(0); chk(v, 8'h55);
		rd(OFS_DATA); chk(v, 8'hC3);
		$display("TB: mode 1 done");
		wr(OFS_CTRL, 8'h20);
		wr(OFS_DATA, 8'h96);
		@(posedge sys_clk);
		#1 chk({6'h00, rxdOe, rxdOut}, 8'h02);
		wait_flag(1); chk(v, 8'h22);
		wr(OFS_CTRL, 8'h10);
		wait_flag(0); chk(v, 8'h11);
		rd(OFS_DATA); chk(v, 8'hFF);
		$display("TB: mode 0 done");
		tally_and_finish();
	end
endmodule
